// *** include/host_bus_regs.svh ***
// Timing counts and reset values for the host local bus interface.
`ifndef HOST_BUS_REGS_SVH
`define HOST_BUS_REGS_SVH
`define CLAIM_WAIT_CYCLES 2'h2
`define PHASE_DIV_BITS 1
`define RESET_PULSE_CYCLES 8'h10
`define ADDR_A20_BIT 20
`define BYTE_EN_IDLE 4'hf
`endif

// *** include/host_bus_pkg.sv ***
// Types for the host local bus interface.
package host_bus_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_CLAIM = 6'h02,
    ST_BACK = 6'h04,
    ST_READY = 6'h08,
    ST_MASTER = 6'h10,
    ST_RELEASE = 6'h20
  } bus_state_t;
endpackage : host_bus_pkg

// *** core/pin_sync.sv ***
// Three-stage synchroniser for asynchronous pin inputs.
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  // A change is accepted only once the second and third stages agree.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      level <= INIT;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level <= s3_q;
      end
    end
  end
endmodule : pin_sync

// *** core/host_local_bus_interface.sv ***
// Host local bus slave, default target and temporary bus master.
// Operation
// - Address lines input, driven when mastering
// - Drive strobe only after lines stable
// - Drive byte enables when mastering
// - Single host clock, derived phase enable
// - Data passes over 16-bit data bus
// - No claim after two clocks: default target
// - Status sampled at strobe, driven mastering
// - Next-address pipelining request, then tri-state
// - Alternate mode: pin is external strobe
// - Ready-in inactive terminates the cycle
// - Ready pulse one clock, high, tri-state
// - Refresh out from timer, input mastering
// - Processor reset on four reset sources
// - Clamp forces address bit 20 low
// - Parity error raises NMI when unmasked
// - Hold request until master completes
`timescale 1ns/10ps
`include "host_bus_regs.svh"
module host_local_bus_interface
  import host_bus_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [26:0] host_addr_i,
  output logic [26:0] host_addr_o,
  output logic host_addr_oe,
  input wire logic host_addr_strobe_n_i,
  output logic host_addr_strobe_n_o,
  output logic host_addr_strobe_n_oe,
  input wire logic [3:0] host_byte_en_n_i,
  output logic [3:0] host_byte_en_n_o,
  output logic host_byte_en_n_oe,
  input wire logic [15:0] host_data_i,
  output logic [15:0] host_data_o,
  output logic host_data_oe,
  input wire logic [2:0] host_status_i,
  output logic [2:0] host_status_o,
  output logic host_status_oe,
  input wire logic host_hold_ack,
  output logic host_hold_req,
  input wire logic local_cycle_claim_n,
  output logic next_addr_req_n_o,
  output logic next_addr_req_n_oe,
  input wire logic alt_cpu_mode,
  input wire logic ready_in_n,
  output logic ready_out_n_o,
  output logic ready_out_n_oe,
  input wire logic refresh_req_n_i,
  output logic refresh_req_n_o,
  output logic refresh_req_n_oe,
  input wire logic timer1_refresh,
  output logic refresh_start,
  input wire logic sys_reset,
  input wire logic shutdown_det,
  input wire logic kbd_ctrl_reset,
  input wire logic fast_cpu_reset,
  output logic cpu_reset_out,
  input wire logic a20_clamp_n,
  input wire logic parity_err_n,
  input wire logic parity_mask_open,
  output logic nmi_out,
  input wire logic dma_req,
  input wire logic master_done,
  input wire logic [26:0] master_addr,
  input wire logic [3:0] master_byte_en_n,
  input wire logic [2:0] master_status,
  input wire logic [15:0] master_wdata,
  input wire logic back_done,
  input wire logic [15:0] back_rdata,
  output logic back_start,
  output logic [26:0] cycle_addr,
  output logic [2:0] cycle_status,
  output logic [15:0] cycle_wdata,
  output logic phase_en
);
  logic rs1_q;
  logic rs_q;
  logic [26:0] addr_s;
  logic ads_n_s;
  logic [3:0] ben_s;
  logic [2:0] stat_s;
  logic [15:0] data_s;
  logic hlda_s;
  logic claim_n_s;
  logic rdyi_n_s;
  logic refin_n_s;
  logic clamp_n_s;
  logic par_n_s;
  logic rdyi_prev_q;
  logic ref_prev_q;
  logic par_prev_q;
  logic [1:0] wait_q;
  logic [1:0] ready_ph_q;
  logic [1:0] na_ph_q;
  logic [1:0] ads_ph_q;
  logic [7:0] rst_cnt_q;
  logic cyc_write_q;
  bus_state_t state_q;

  // Reset is released through two flops so every process sees a clean edge.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rs1_q <= 1'b0;
      rs_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs_q <= rs1_q;
    end
  end

  pin_sync #(.W(27), .INIT(27'h0)) u_addr (.clock(clock), .rst_n(rs_q), .pin(host_addr_i), .level(addr_s));
  pin_sync #(.W(4), .INIT(4'hf)) u_ben (.clock(clock), .rst_n(rs_q), .pin(host_byte_en_n_i), .level(ben_s));
  pin_sync #(.W(3), .INIT(3'h0)) u_stat (.clock(clock), .rst_n(rs_q), .pin(host_status_i), .level(stat_s));
  pin_sync #(.W(16), .INIT(16'h0)) u_data (.clock(clock), .rst_n(rs_q), .pin(host_data_i), .level(data_s));
  // Control pins reset to their idle levels, so no false edge or acknowledge follows reset.
  pin_sync #(.W(7), .INIT(7'h5f)) u_ctl (.clock(clock), .rst_n(rs_q),
    .pin({host_addr_strobe_n_i, host_hold_ack, local_cycle_claim_n, ready_in_n, refresh_req_n_i,
          a20_clamp_n, parity_err_n}),
    .level({ads_n_s, hlda_s, claim_n_s, rdyi_n_s, refin_n_s, clamp_n_s, par_n_s}));

  function automatic logic rise(input logic prev, input logic now);
    rise = !prev && now;
  endfunction : rise

  always_ff @(posedge clock or negedge rs_q) begin
    if (!rs_q) phase_en <= 1'b0;
    else phase_en <= ~phase_en;
  end

  always_ff @(posedge clock or negedge rs_q) begin
    if (!rs_q) begin
      rdyi_prev_q <= 1'b1;
      ref_prev_q <= 1'b1;
      par_prev_q <= 1'b1;
    end else begin
      rdyi_prev_q <= rdyi_n_s;
      ref_prev_q <= refin_n_s;
      par_prev_q <= par_n_s;
    end
  end

  // Cycle state machine: claim window, backplane, ready, and mastership.
  always_ff @(posedge clock or negedge rs_q) begin
    if (!rs_q) begin
      state_q <= ST_IDLE;
      wait_q <= 2'h0;
      back_start <= 1'b0;
      cycle_addr <= 27'h0;
      cycle_status <= 3'h0;
      cycle_wdata <= 16'h0;
      host_data_o <= 16'h0;
      cyc_write_q <= 1'b0;
      host_hold_req <= 1'b0;
    end else begin
      back_start <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (dma_req) begin
            host_hold_req <= 1'b1;
            state_q <= ST_MASTER;
          end else if (!ads_n_s) begin
            cycle_status <= stat_s;
            cyc_write_q <= stat_s[0];
            cycle_addr <= clamp_n_s ? addr_s : (addr_s & ~(27'h1 << (`ADDR_A20_BIT - 2)));
            wait_q <= 2'h0;
            state_q <= ST_CLAIM;
          end
        end
        ST_CLAIM: begin
          if (!claim_n_s) begin
            state_q <= ST_IDLE;
          end else if (wait_q == `CLAIM_WAIT_CYCLES - 2'h1) begin
            back_start <= 1'b1;
            cycle_wdata <= data_s;
            state_q <= ST_BACK;
          end else begin
            wait_q <= wait_q + 2'h1;
          end
        end
        ST_BACK: begin
          if (back_done) begin
            if (!cyc_write_q) host_data_o <= back_rdata;
            state_q <= ST_READY;
          end
        end
        ST_READY: begin
          if (rise(rdyi_prev_q, rdyi_n_s) || ready_ph_q == 2'h2) state_q <= ST_IDLE;
        end
        ST_MASTER: begin
          if (master_done) begin
            state_q <= ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          if (!host_addr_oe && !host_addr_strobe_n_oe) begin
            host_hold_req <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rs_q) begin
    if (!rs_q) host_data_oe <= 1'b0;
    else host_data_oe <= !cyc_write_q &&
      ((state_q == ST_BACK && back_done) || (state_q == ST_READY && ready_ph_q == 2'h1));
  end

  always_ff @(posedge clock or negedge rs_q) begin
    if (!rs_q) begin
      ready_ph_q <= 2'h0;
      ready_out_n_o <= 1'b1;
      ready_out_n_oe <= 1'b0;
    end else begin
      case (ready_ph_q)
        2'h0: if (state_q == ST_BACK && back_done) begin
          ready_ph_q <= 2'h1;
          ready_out_n_o <= 1'b0;
          ready_out_n_oe <= 1'b1;
        end
        2'h1: begin
          ready_ph_q <= 2'h2;
          ready_out_n_o <= 1'b1;
        end
        default: begin
          ready_ph_q <= 2'h0;
          ready_out_n_oe <= 1'b0;
        end
      endcase
    end
  end

  // next-address request; external strobe in alternate mode
  always_ff @(posedge clock or negedge rs_q) begin
    if (!rs_q) begin
      na_ph_q <= 2'h0;
      next_addr_req_n_o <= 1'b1;
      next_addr_req_n_oe <= 1'b0;
    end else begin
      case (na_ph_q)
        2'h0: if ((!alt_cpu_mode && state_q == ST_CLAIM && wait_q == 2'h1 && claim_n_s) ||
                  (alt_cpu_mode && ads_ph_q == 2'h1)) begin
          na_ph_q <= 2'h1;
          next_addr_req_n_o <= 1'b0;
          next_addr_req_n_oe <= 1'b1;
        end
        2'h1: begin
          na_ph_q <= 2'h2;
          next_addr_req_n_o <= 1'b1;
        end
        default: begin
          na_ph_q <= 2'h0;
          next_addr_req_n_oe <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rs_q) begin
    if (!rs_q) begin
      host_addr_o <= 27'h0;
      host_byte_en_n_o <= `BYTE_EN_IDLE;
      host_status_o <= 3'h0;
      host_addr_oe <= 1'b0;
      host_byte_en_n_oe <= 1'b0;
      host_status_oe <= 1'b0;
    end else begin
      host_addr_oe <= state_q == ST_MASTER && hlda_s;
      host_byte_en_n_oe <= state_q == ST_MASTER && hlda_s;
      host_status_oe <= state_q == ST_MASTER && hlda_s;
      host_addr_o <= master_addr;
      host_byte_en_n_o <= master_byte_en_n;
      host_status_o <= master_status;
    end
  end

  // strobe one cycle after lines settle
  always_ff @(posedge clock or negedge rs_q) begin
    if (!rs_q) begin
      ads_ph_q <= 2'h0;
      host_addr_strobe_n_o <= 1'b1;
      host_addr_strobe_n_oe <= 1'b0;
    end else if (!(state_q == ST_MASTER && hlda_s)) begin
      ads_ph_q <= 2'h0;
      host_addr_strobe_n_o <= 1'b1;
      host_addr_strobe_n_oe <= 1'b0;
    end else begin
      host_addr_strobe_n_oe <= host_addr_oe;
      if (host_addr_oe && ads_ph_q == 2'h0) begin
        ads_ph_q <= 2'h1;
        host_addr_strobe_n_o <= 1'b0;
      end else begin
        if (ads_ph_q == 2'h1) ads_ph_q <= 2'h2;
        host_addr_strobe_n_o <= 1'b1;
      end
    end
  end

  // refresh driven from timer, input in master mode
  always_ff @(posedge clock or negedge rs_q) begin
    if (!rs_q) begin
      refresh_req_n_o <= 1'b1;
      refresh_req_n_oe <= 1'b1;
      refresh_start <= 1'b0;
    end else begin
      refresh_req_n_oe <= state_q != ST_MASTER;
      refresh_req_n_o <= !timer1_refresh;
      refresh_start <= (state_q == ST_MASTER) ? (ref_prev_q && !refin_n_s) : timer1_refresh;
    end
  end

  always_ff @(posedge clock or negedge rs_q) begin
    if (!rs_q) begin
      rst_cnt_q <= `RESET_PULSE_CYCLES;
      cpu_reset_out <= 1'b1;
    end else begin
      if (sys_reset || shutdown_det || kbd_ctrl_reset || fast_cpu_reset) rst_cnt_q <= `RESET_PULSE_CYCLES;
      else if (rst_cnt_q != 8'h0) rst_cnt_q <= rst_cnt_q - 8'h1;
      cpu_reset_out <= sys_reset || shutdown_det || kbd_ctrl_reset || fast_cpu_reset || rst_cnt_q != 8'h0;
    end
  end

  // parity error to NMI; sticky until the mask closes, set wins.
  always_ff @(posedge clock or negedge rs_q) begin
    if (!rs_q) nmi_out <= 1'b0;
    else if (par_prev_q && !par_n_s && parity_mask_open) nmi_out <= 1'b1;
    else if (!parity_mask_open) nmi_out <= 1'b0;
  end

  property p_claim_wait;
    @(posedge clock) disable iff (!rs_q)
      (state_q == ST_IDLE && !dma_req && !ads_n_s) ##1 (claim_n_s [*2]) |-> ##1 (back_start || state_q == ST_BACK);
  endproperty
  a_claim_wait: assert property (p_claim_wait) else $error("default target not taken");

  sequence s_ready_tail;
    ##1 (ready_out_n_o && ready_out_n_oe) ##1 !ready_out_n_oe;
  endsequence

  property p_ready_pulse;
    @(posedge clock) disable iff (!rs_q)
      $fell(ready_out_n_o) |-> s_ready_tail;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready pulse shape wrong");

  property p_drive_ack;
    @(posedge clock) disable iff (!rs_q)
      host_addr_oe |-> host_hold_req && $past(hlda_s);
  endproperty
  a_drive_ack: assert property (p_drive_ack) else $error("bus driven without acknowledge");

  property p_nmi;
    @(posedge clock) disable iff (!rs_q)
      (par_prev_q && !par_n_s && parity_mask_open) |=> nmi_out;
  endproperty
  a_nmi: assert property (p_nmi) else $error("parity NMI missing");

  property p_reset;
    @(posedge clock) disable iff (!rs_q)
      (sys_reset || fast_cpu_reset) |=> cpu_reset_out [*2];
  endproperty
  a_reset: assert property (p_reset) else $error("cpu reset not asserted");

  property p_strobe;
    @(posedge clock) disable iff (!rs_q)
      (!host_addr_strobe_n_o && host_addr_strobe_n_oe) |-> host_addr_oe && host_byte_en_n_oe && host_status_oe;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe before lines driven");

  sequence s_na_tail;
    ##1 next_addr_req_n_o ##1 !next_addr_req_n_oe;
  endsequence

  property p_na;
    @(posedge clock) disable iff (!rs_q)
      $fell(next_addr_req_n_o) |-> s_na_tail;
  endproperty
  a_na: assert property (p_na) else $error("next address sequence wrong");

  property p_hold;
    @(posedge clock) disable iff (!rs_q)
      (state_q == ST_IDLE && dma_req) |=> host_hold_req;
  endproperty
  a_hold: assert property (p_hold) else $error("hold request missing");
endmodule : host_local_bus_interface

// *** sim/host_cpu_model.sv ***
// Host processor and claiming local device, seen from the bus interface.
`timescale 1ns/10ps
module host_cpu_model (
  input wire logic clock,
  input wire logic host_hold_req,
  output logic host_hold_ack,
  output logic cpu_ads_n,
  output logic [26:0] cpu_addr,
  output logic [3:0] cpu_ben_n,
  output logic [2:0] cpu_st,
  output logic [15:0] cpu_data,
  output logic local_cycle_claim_n
);
  logic [1:0] ack_q = 2'h0;
  initial begin
    host_hold_ack = 1'b0;
    cpu_ads_n = 1'b1;
    {cpu_addr, cpu_ben_n, cpu_st, cpu_data} = '0;
    // The board pull-up keeps an unclaimed line high.
    local_cycle_claim_n = 1'b1;
  end
  always @(negedge clock) begin
    ack_q <= {ack_q[0], host_hold_req};
    host_hold_ack <= ack_q[1] & host_hold_req;
  end
  task automatic start(input logic [26:0] a, input logic [2:0] st, input logic [15:0] d, input logic claim);
    @(negedge clock);
    cpu_addr = a;
    cpu_st = st;
    cpu_data = d;
    cpu_ben_n = 4'h0;
    cpu_ads_n = 1'b0;
    // The strobe spans two clocks, since the pin filter drops a one-clock pulse.
    @(negedge clock);
    if (claim) local_cycle_claim_n = 1'b0;
    @(negedge clock);
    cpu_ads_n = 1'b1;
    @(negedge clock);
    local_cycle_claim_n = 1'b1;
  endtask : start
  // Released lines flip so that a stale value is never read as valid.
  task automatic release_bus();
    cpu_addr = ~cpu_addr;
    cpu_data = ~cpu_data;
    cpu_st = ~cpu_st;
    cpu_ben_n = ~cpu_ben_n;
  endtask : release_bus
endmodule : host_cpu_model

// *** sim/host_local_bus_interface_tb.sv ***
// Self-checking bench for the host local bus interface.
`timescale 1ns/10ps
`include "host_bus_regs.svh"
module host_local_bus_interface_tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic ready_in_n = 1'b1;
  logic [26:0] host_addr_i, host_addr_o, cpu_addr, master_addr, cycle_addr, exp_addr;
  logic [15:0] host_data_i, host_data_o, cpu_data, master_wdata, back_rdata, cycle_wdata;
  logic [3:0] host_byte_en_n_i, host_byte_en_n_o, cpu_ben_n, master_byte_en_n;
  logic [2:0] host_status_i, host_status_o, cpu_st, master_status, cycle_status;
  logic host_addr_oe, host_addr_strobe_n_i, host_addr_strobe_n_o, host_addr_strobe_n_oe, cpu_ads_n;
  logic host_byte_en_n_oe, host_data_oe, host_status_oe, host_hold_ack, host_hold_req, local_cycle_claim_n;
  logic next_addr_req_n_o, next_addr_req_n_oe, alt_cpu_mode, ready_out_n_o, ready_out_n_oe;
  logic refresh_req_n_i, refresh_req_n_o, refresh_req_n_oe, ref_in, timer1_refresh, refresh_start;
  logic sys_reset, shutdown_det, kbd_ctrl_reset, fast_cpu_reset, cpu_reset_out, a20_clamp_n, parity_err_n;
  logic parity_mask_open, nmi_out, dma_req, master_done, back_done, back_start, phase_en, na_seen, p;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  int n;
  assign host_addr_i = host_addr_oe ? host_addr_o : cpu_addr;
  assign host_addr_strobe_n_i = host_addr_strobe_n_oe ? host_addr_strobe_n_o : cpu_ads_n;
  assign host_byte_en_n_i = host_byte_en_n_oe ? host_byte_en_n_o : cpu_ben_n;
  assign host_status_i = host_status_oe ? host_status_o : cpu_st;
  assign host_data_i = host_data_oe ? host_data_o : cpu_data;
  assign refresh_req_n_i = refresh_req_n_oe ? refresh_req_n_o : ref_in;
  host_local_bus_interface DUT (.*);
  host_cpu_model cpu (.*);
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick();
    @(negedge clock);
    n++;
    if (next_addr_req_n_oe === 1'b1 && next_addr_req_n_o === 1'b0) na_seen = 1'b1;
  endtask : tick
  task automatic t_reset();
    repeat (20) @(negedge clock);
    chk("rst_cpu", cpu_reset_out, 1);
    chk("rst_oe", {host_addr_oe, host_data_oe, ready_out_n_oe, refresh_req_n_oe}, 4'h1);
    chk("rst_hold", host_hold_req, 0);
    rst_n = 1'b1;
    repeat (10) @(negedge clock);
    chk("rst_stretch", cpu_reset_out, 1);
    n = 0;
    while (cpu_reset_out !== 1'b0 && n < 30) tick();
    chk("rst_end", cpu_reset_out, 0);
  endtask : t_reset
  task automatic t_misc();
    p = phase_en;
    @(negedge clock);
    // A logical not keeps the expected value one bit wide when it is widened.
    chk("phase", phase_en, !p);
    timer1_refresh = 1'b1;
    n = 0;
    while (refresh_req_n_o !== 1'b0 && n < 8) tick();
    chk("ref_out", {refresh_req_n_oe, refresh_req_n_o}, 2'h2);
    timer1_refresh = 1'b0;
  endtask : t_misc
  task automatic t_host(input logic clamp_n, input logic [26:0] a, input logic [2:0] st);
    a20_clamp_n = clamp_n;
    exp_addr = a;
    if (!clamp_n) exp_addr[`ADDR_A20_BIT-2] = 1'b0;
    na_seen = 1'b0;
    cpu.start(a, st, 16'h3c5a, 1'b0);
    n = 0;
    while (back_start !== 1'b1 && n < 20) tick();
    chk("back_start", back_start, 1);
    chk("cyc_addr", cycle_addr, exp_addr);
    chk("cyc_status", cycle_status, st);
    chk("cyc_wdata", cycle_wdata, 16'h3c5a);
    chk("next_addr", na_seen, 1);
    back_rdata = 16'hc3a5;
    back_done = 1'b1;
    @(negedge clock);
    back_done = 1'b0;
    n = 0;
    while (!(ready_out_n_oe === 1'b1 && ready_out_n_o === 1'b0) && n < 6) tick();
    chk("rdy_low", {ready_out_n_oe, ready_out_n_o}, 2'h2);
    // Read data must stand with ready low; a write cycle leaves the data bus alone.
    chk("rd_oe", host_data_oe, !st[0]);
    if (!st[0]) chk("rd_data", host_data_o, 16'hc3a5);
    @(negedge clock);
    chk("rdy_high", {ready_out_n_oe, ready_out_n_o}, 2'h3);
    @(negedge clock);
    chk("rdy_off", ready_out_n_oe, 0);
    cpu.release_bus();
    repeat (4) @(negedge clock);
  endtask : t_host
  task automatic t_claim();
    p = 1'b0;
    cpu.start(27'h0001234, 3'h4, 16'h0f0f, 1'b1);
    repeat (12) begin
      @(negedge clock);
      p = p | back_start;
    end
    chk("claimed", p, 0);
    cpu.release_bus();
  endtask : t_claim
  task automatic t_master();
    master_addr = 27'h5a5a5a5;
    master_byte_en_n = 4'h3;
    master_status = 3'h6;
    alt_cpu_mode = 1'b1;
    dma_req = 1'b1;
    n = 0;
    while (host_hold_req !== 1'b1 && n < 4) tick();
    chk("hold_req", host_hold_req, 1);
    dma_req = 1'b0;
    n = 0;
    while (host_addr_oe !== 1'b1 && n < 12) tick();
    chk("ack_first", host_hold_ack, 1);
    chk("m_addr", {host_addr_oe, host_addr_o}, {1'b1, 27'h5a5a5a5});
    chk("m_ben", {host_byte_en_n_oe, host_byte_en_n_o}, 5'h13);
    chk("m_status", {host_status_oe, host_status_o}, 4'he);
    na_seen = 1'b0;
    n = 0;
    while (host_addr_strobe_n_o !== 1'b0 && n < 3) tick();
    chk("m_ads", {host_addr_strobe_n_oe, host_addr_strobe_n_o, host_addr_oe}, 3'h5);
    tick();
    chk("m_ads_end", host_addr_strobe_n_o, 1);
    chk("ext_ads", na_seen, 1);
    chk("ref_in_mode", refresh_req_n_oe, 0);
    ref_in = 1'b0;
    n = 0;
    while (refresh_start !== 1'b1 && n < 8) tick();
    chk("ref_start", refresh_start, 1);
    ref_in = 1'b1;
    chk("hold_kept", host_hold_req, 1);
    master_done = 1'b1;
    @(negedge clock);
    master_done = 1'b0;
    n = 0;
    while (host_addr_oe !== 1'b0 && n < 6) tick();
    chk("release_first", {host_addr_oe, host_hold_req}, 2'h1);
    n = 0;
    while (host_hold_req !== 1'b0 && n < 6) tick();
    chk("hold_drop", host_hold_req, 0);
    alt_cpu_mode = 1'b0;
    repeat (6) @(negedge clock);
  endtask : t_master
  task automatic t_resets();
    for (int i = 0; i < 4; i++) begin
      {fast_cpu_reset, kbd_ctrl_reset, shutdown_det, sys_reset} = 4'h1 << i;
      n = 0;
      while (cpu_reset_out !== 1'b1 && n < 10) tick();
      chk("src_reset", cpu_reset_out, 1);
      {fast_cpu_reset, kbd_ctrl_reset, shutdown_det, sys_reset} = 4'h0;
      n = 0;
      while (cpu_reset_out !== 1'b0 && n < 40) tick();
      chk("src_end", cpu_reset_out, 0);
    end
  endtask : t_resets
  task automatic t_parity(input logic open);
    parity_mask_open = open;
    parity_err_n = 1'b0;
    repeat (2) @(negedge clock);
    parity_err_n = 1'b1;
    repeat (8) @(negedge clock);
    chk("nmi", nmi_out, open);
    parity_mask_open = 1'b0;
    repeat (6) @(negedge clock);
    chk("nmi_clear", nmi_out, 0);
  endtask : t_parity
  task automatic report_and_stop();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    {sys_reset, shutdown_det, kbd_ctrl_reset, fast_cpu_reset, dma_req, master_done, back_done} = '0;
    {timer1_refresh, alt_cpu_mode, parity_mask_open, na_seen, p} = '0;
    {a20_clamp_n, parity_err_n, ref_in} = 3'h7;
    {master_addr, master_wdata, master_byte_en_n, master_status, back_rdata} = '0;
    t_reset();
    t_misc();
    t_host(1'b0, 27'h04c1234, 3'h4);
    t_host(1'b1, 27'h04c1234, 3'h5);
    t_claim();
    t_master();
    t_resets();
    t_parity(1'b0);
    t_parity(1'b1);
    report_and_stop();
  end
endmodule : host_local_bus_interface_tb
